// File: hw/ccp_pkg.sv
/*
 * Shared constants for the clock source and prescaler configuration block:
 * register offsets, field positions, reset values, switch timing and the
 * decode functions for every prescaler and multiplier field.
 * Assumes byte addressing on a 32-bit register bus.
 */
package ccp_pkg;

   // Register byte offsets
   localparam logic [3:0] CCP_OFS_OSC_CTRL = 4'h0;
   localparam logic [3:0] CCP_OFS_CFG_MAIN = 4'h4;

   // Reset values and write masks
   localparam logic [31:0] CCP_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CCP_CFG_WMASK = 32'hbfff_fff3; // Bit 30 and status bits 3:2 are not writable
   localparam logic [31:0] CCP_USB_MASK = 32'h80c0_0000;
   localparam logic [31:0] CCP_ZERO_WORD = 32'h0000_0000;

   // Oscillator control fields
   localparam int CCP_RC8_EN_BIT = 0;
   localparam int CCP_RC8_RDY_BIT = 1;
   localparam int CCP_CKM_BIT = 19;

   // Main configuration fields
   localparam int CCP_SCS_LSB = 0;
   localparam int CCP_SYSCLK_SOURCE_STATUS_LSB = 2;
   localparam int CCP_AHB_LSB = 4;
   localparam int CCP_APB1_LSB = 8;
   localparam int CCP_APB2_LSB = 11;
   localparam int CCP_ADC_LSB = 14;
   localparam int CCP_PLL_SOURCE_SELECT_BIT = 16;
   localparam int CCP_PREDV_BIT = 17;
   localparam int CCP_PLL_MULTIPLIER_LSB = 18;
   localparam int CCP_USB_LSB = 22;
   localparam int CCP_CKOUT_LSB = 24;
   localparam int CCP_ADC_HI_BIT = 28;
   localparam int CCP_PLL_MULTIPLIER_HI_BIT = 29;
   localparam int CCP_USB_HI_BIT = 31;

   // System clock sources and PLL reference codes
   localparam logic [1:0] CCP_SRC_RC8 = 2'h0;
   localparam logic [1:0] CCP_SRC_XTAL = 2'h1;
   localparam logic [1:0] CCP_SRC_PLL = 2'h2;
   localparam logic [1:0] CCP_SRC_RSVD = 2'h3;
   localparam logic [1:0] CCP_REF_RC48 = 2'h2;

   // Switch latency of the system clock multiplexer, in core_clk cycles
   localparam logic [3:0] CCP_SWITCH_CYCLES = 4'h4;
   localparam int CCP_RATIO_W = 10;

   typedef enum logic [1:0] {
      CCP_SW_IDLE = 2'b01,
      CCP_SW_BUSY = 2'b10
   } ccp_sw_state_t;

   // AHB prescaler ratio
   function automatic logic [9:0] ccp_ahb_ratio(input logic [3:0] c);
      logic [9:0] r;
      r = 10'h001;
      if (c[3]) begin
         case (c[2:0])
            3'h0: r = 10'h002;
            3'h1: r = 10'h004;
            3'h2: r = 10'h008;
            3'h3: r = 10'h010;
            3'h4: r = 10'h040;
            3'h5: r = 10'h080;
            3'h6: r = 10'h100;
            default: r = 10'h200;
         endcase
      end
      return r;
   endfunction

   // APB1 and APB2 prescaler ratio
   function automatic logic [9:0] ccp_apb_ratio(input logic [2:0] c);
      logic [9:0] r;
      r = 10'h001;
      if (c[2]) begin
         r = 10'h002 << c[1:0];
      end
      return r;
   endfunction

   // ADC prescaler ratio; codes 1x.. count the AHB clock
   function automatic logic [9:0] ccp_adc_ratio(input logic [3:0] c);
      logic [9:0] r;
      r = 10'h002;
      if (c[3]) begin
         r = {7'h00, c[1:0], 1'b1} + 10'h002;
      end else begin
         case (c[2:0])
            3'h0: r = 10'h002;
            3'h1: r = 10'h004;
            3'h2: r = 10'h006;
            3'h3: r = 10'h008;
            3'h4: r = 10'h002;
            3'h5: r = 10'h00c;
            3'h6: r = 10'h008;
            default: r = 10'h010;
         endcase
      end
      return r;
   endfunction

   // PLL factor times two, so that 6.5 stays whole
   function automatic logic [5:0] ccp_pll_mult_x2(input logic [4:0] c);
      logic [5:0] r;
      if (c < 5'h0d) begin
         r = 6'({1'b0, c} + 6'h02) << 1;
      end else if (c == 5'h0d) begin
         r = 6'h0d;
      end else if (c < 5'h10) begin
         r = 6'h20;
      end else if (c < 5'h1e) begin
         r = 6'({1'b0, c} + 6'h01) << 1;
      end else begin
         r = 6'h3e;
      end
      return r;
   endfunction

   // USB divisor times two, so that 1.5, 2.5 and 3.5 stay whole
   function automatic logic [3:0] ccp_usb_div_x2(input logic [2:0] c);
      logic [3:0] r;
      case (c)
         3'h0: r = 4'h3;
         3'h1: r = 4'h2;
         3'h2: r = 4'h5;
         3'h3: r = 4'h4;
         3'h4: r = 4'h6;
         3'h5: r = 4'h7;
         default: r = 4'h8;
      endcase
      return r;
   endfunction

endpackage

// File: hw/ccp_div_if.sv
/*
 * Carrier between the configuration core and one tick divider.
 * Assumes all signals live on core_clk.
 */
`timescale 1ns/100ps
interface ccp_div_if;
   logic in_tick;
   logic [9:0] ratio;
   logic out_tick;
   modport div (input in_tick, input ratio, output out_tick);
   modport ctl (output in_tick, output ratio, input out_tick);
endinterface // ccp_div_if

// File: hw/ccp_tick_div.sv
/*
 * Enable-pulse divider: one output tick per ratio input ticks.
 * Assumes in_tick is a one-cycle pulse on core_clk; ratio 0 acts as 1.
 */
`timescale 1ns/100ps
module ccp_tick_div
   import ccp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   ccp_div_if.div bus
);
   logic [CCP_RATIO_W-1:0] cnt_reg;
   logic [CCP_RATIO_W-1:0] ratio_reg;
   logic tick_reg;
   logic wrap;

   // Last input tick of the current period
   assign wrap = (cnt_reg + 10'h001 >= ratio_reg);
   assign bus.out_tick = tick_reg;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg <= '0;
         ratio_reg <= 10'h001;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= bus.in_tick & wrap;
         if (bus.in_tick) begin
            cnt_reg <= wrap ? '0 : cnt_reg + 10'h001;
            if (wrap) begin
               ratio_reg <= bus.ratio; // New ratio only between whole periods
            end
         end
      end
   end
endmodule // ccp_tick_div

// File: hw/ccp_rc8_ctrl.sv
/*
 * Enable and ready logic of the internal 8 MHz RC oscillator.
 * Assumes osc_stable and xtal_stuck are already synchronised to core_clk.
 */
`timescale 1ns/100ps
module ccp_rc8_ctrl (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sw_wr,
   input wire logic sw_val,
   input wire logic sysclk_is_rc8,
   input wire logic wake_pulse,
   input wire logic xtal_stuck,
   input wire logic monitor_en,
   input wire logic osc_stable,
   output logic rc8_enable,
   output logic rc8_ready
);
   logic en_reg;
   logic rdy_reg;
   logic hw_set;

   assign hw_set = wake_pulse | (monitor_en & xtal_stuck);
   assign rc8_enable = en_reg;
   assign rc8_ready = rdy_reg;

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         en_reg <= 1'b0;
         rdy_reg <= 1'b0;
      end else begin
         if (hw_set) begin
            en_reg <= 1'b1;
         end else if (sw_wr) begin
            en_reg <= sw_val | sysclk_is_rc8;
         end
         rdy_reg <= osc_stable & (en_reg | monitor_en);
      end
   end
endmodule // ccp_rc8_ctrl

// File: hw/ccp_clock_config.sv
/*
 * Clock source and prescaler configuration: oscillator control register,
 * main clock configuration register, system clock switch sequencing and
 * enable-pulse prescalers for the AHB, APB1, APB2 and ADC clocks.
 * Assumes an Avalon-MM master on core_clk, oscillator status arriving
 * asynchronously on pins, and the power controller and second
 * configuration register living on core_clk.
 */
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps

module ccp_clock_config
   import ccp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rc8_osc_stable,
   input wire logic crystal_stuck,
   input wire logic low_power_exit,
   input wire logic usb_clock_enabled,
   input wire logic predv_lsb_wr,
   input wire logic predv_lsb_wdata,
   input wire logic predv_upper_zero,
   input wire logic adc_divider_msb,
   input wire logic pll_preselect,
   output logic rc8_enable,
   output logic rc8_ready,
   output logic [1:0] sysclk_source_status,
   output logic ahb_tick,
   output logic apb1_tick,
   output logic apb2_tick,
   output logic adc_tick,
   output logic [3:0] clock_out_source,
   output logic [5:0] pll_mult_x2,
   output logic [3:0] usb_div_x2,
   output logic [1:0] pll_ref_source,
   output logic predivider_low_bit,
   output logic predv_halve
);

   localparam int NDIV = 4;

   // Register state
   logic [31:0] cfg_reg;
   logic [31:0] cfg_next;
   logic ckm_reg;
   logic [31:0] rdata_reg;
   logic wait_reg;
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] sysclk_source_status_reg;
   logic [1:0] target_reg;
   logic [3:0] sw_cnt_reg;
   ccp_sw_state_t sw_state_reg;
   logic [3:0] ckout_reg;
   logic [5:0] mult_reg;
   logic [3:0] usb_reg;
   logic [1:0] ref_reg;
   logic halve_reg;

   // Bus decode wires
   logic req;
   logic take;
   logic hit_osc;
   logic hit_cfg;
   logic wr_osc;
   logic wr_cfg;
   logic [31:0] bmask;
   logic [31:0] cfg_wmask;
   logic [31:0] cfg_written;
   logic [31:0] osc_word;
   logic [31:0] read_word;

   // Clock path wires
   logic osc_stable_s;
   logic xtal_stuck_s;
   logic [1:0] scs;
   logic xtal_in_use;
   logic force_rc8;
   logic [3:0] ckout_code;
   logic [3:0] adc_code;
   logic adc_from_ahb;
   logic [4:0] mf_code;
   logic [2:0] usb_code;
   logic sw_done;

   // Avalon request is taken on the edge where waitrequest is low
   assign req = avs_read | avs_write;
   assign take = req & ~wait_reg;
   assign hit_osc = (avs_address == CCP_OFS_OSC_CTRL);
   assign hit_cfg = (avs_address == CCP_OFS_CFG_MAIN);
   assign wr_osc = take & avs_write & hit_osc;
   assign wr_cfg = take & avs_write & hit_cfg;
   assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   assign cfg_wmask = bmask & CCP_CFG_WMASK & ~(usb_clock_enabled ? CCP_USB_MASK : CCP_ZERO_WORD);
   assign cfg_written = (cfg_reg & ~cfg_wmask) | (avs_writedata & cfg_wmask);

   // Synchronised pin levels, only the second stage is read
   assign osc_stable_s = sync2_reg[0];
   assign xtal_stuck_s = sync2_reg[1];

   // Crystal feeds the system clock directly or through the PLL
   assign scs = cfg_reg[CCP_SCS_LSB +: 2];
   assign xtal_in_use = (sysclk_source_status_reg == CCP_SRC_XTAL) |
                        ((sysclk_source_status_reg == CCP_SRC_PLL) & cfg_reg[CCP_PLL_SOURCE_SELECT_BIT] & ~pll_preselect);
   assign force_rc8 = low_power_exit | (ckm_reg & xtal_stuck_s & xtal_in_use);

   // Next value of the main configuration register
   always_comb begin
      cfg_next = wr_cfg ? cfg_written : cfg_reg;
      if (predv_lsb_wr & ~wr_cfg) begin
         cfg_next[CCP_PREDV_BIT] = predv_lsb_wdata;
      end
      // Hardware forcing of the source select wins over software
      if (force_rc8) begin
         cfg_next[CCP_SCS_LSB +: 2] = CCP_SRC_RC8;
      end
      cfg_next[CCP_SYSCLK_SOURCE_STATUS_LSB +: 2] = sysclk_source_status_reg;
   end

   // Oscillator control read image
   assign osc_word = (CCP_ZERO_WORD | (32'(ckm_reg) << CCP_CKM_BIT)
                     | (32'(rc8_ready) << CCP_RC8_RDY_BIT)
                     | (32'(rc8_enable) << CCP_RC8_EN_BIT));

   // Read mux; unmapped offsets read as zero
   assign read_word = hit_osc ? osc_word :
                      hit_cfg ? cfg_reg : CCP_ZERO_WORD;

   // Bus handshake: one wait state, then a single ready cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wait_reg <= 1'b1;
         rdata_reg <= CCP_ZERO_WORD;
      end else begin
         wait_reg <= ~(req & wait_reg);
         if (req & wait_reg) begin
            rdata_reg <= read_word;
         end
      end
   end

   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rdata_reg;

   // Two-flop synchronisers for the oscillator status pins
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
      end else begin
         sync1_reg <= {crystal_stuck, rc8_osc_stable};
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_reg <= CCP_CFG_RESET;
         ckm_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         if (wr_osc & avs_byteenable[2]) begin
            ckm_reg <= avs_writedata[CCP_CKM_BIT];
         end
      end
   end

   // RC oscillator enable and ready
   ccp_rc8_ctrl u_rc8 (
      .core_clk(core_clk),
      .rst(rst),
      .sw_wr(wr_osc & avs_byteenable[0]),
      .sw_val(avs_writedata[CCP_RC8_EN_BIT]),
      .sysclk_is_rc8(sysclk_source_status_reg == CCP_SRC_RC8),
      .wake_pulse(low_power_exit),
      .xtal_stuck(xtal_stuck_s),
      .monitor_en(ckm_reg),
      .osc_stable(osc_stable_s),
      .rc8_enable(rc8_enable),
      .rc8_ready(rc8_ready)
   );

   // Switch completes after the multiplexer latency
   assign sw_done = (sw_cnt_reg == CCP_SWITCH_CYCLES);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sw_state_reg <= CCP_SW_IDLE;
         sysclk_source_status_reg <= CCP_SRC_RC8;
         target_reg <= CCP_SRC_RC8;
         sw_cnt_reg <= 4'h0;
      end else begin
         unique case (sw_state_reg)
            CCP_SW_IDLE: begin
               sw_cnt_reg <= 4'h0;
               // Reserved select code leaves the source unchanged
               if (scs != sysclk_source_status_reg && scs != CCP_SRC_RSVD) begin
                  target_reg <= scs;
                  sw_state_reg <= CCP_SW_BUSY;
               end
            end
            CCP_SW_BUSY: begin
               sw_cnt_reg <= sw_cnt_reg + 4'h1;
               if (sw_done) begin
                  sysclk_source_status_reg <= target_reg;
                  sw_state_reg <= CCP_SW_IDLE;
               end
            end
         endcase
      end
   end

   assign sysclk_source_status = sysclk_source_status_reg;

   assign ckout_code = cfg_reg[CCP_CKOUT_LSB +: 4];
   assign mf_code = {cfg_reg[CCP_PLL_MULTIPLIER_HI_BIT], cfg_reg[CCP_PLL_MULTIPLIER_LSB +: 4]};
   assign usb_code = {cfg_reg[CCP_USB_HI_BIT], cfg_reg[CCP_USB_LSB +: 2]};
   assign adc_code = {adc_divider_msb, cfg_reg[CCP_ADC_HI_BIT], cfg_reg[CCP_ADC_LSB +: 2]};
   assign adc_from_ahb = adc_code[3];

   // Registered decode of multiplexer and factor codes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ckout_reg <= 4'h0;
         mult_reg <= 6'h04;
         usb_reg <= 4'h3;
         ref_reg <= CCP_SRC_RC8;
         halve_reg <= 1'b0;
      end else begin
         // Codes 00xx and the two unused top codes stop the output
         ckout_reg <= (ckout_code[3:2] == 2'h0 || ckout_code[3:1] == 3'h7) ? 4'h0 : ckout_code;
         mult_reg <= ccp_pll_mult_x2(mf_code);
         usb_reg <= ccp_usb_div_x2(usb_code);
         ref_reg <= ~cfg_reg[CCP_PLL_SOURCE_SELECT_BIT] ? CCP_SRC_RC8 :
                    (pll_preselect ? CCP_REF_RC48 : CCP_SRC_XTAL);
         halve_reg <= predv_upper_zero & cfg_reg[CCP_PREDV_BIT];
      end
   end

   assign clock_out_source = ckout_reg;
   assign pll_mult_x2 = mult_reg;
   assign usb_div_x2 = usb_reg;
   assign pll_ref_source = ref_reg;
   assign predivider_low_bit = cfg_reg[CCP_PREDV_BIT];
   assign predv_halve = halve_reg;

   // Prescaler chain: 0 AHB, 1 APB1, 2 APB2, 3 ADC
   ccp_div_if div_bus[NDIV] ();
   logic [NDIV-1:0] src_tick;
   logic [NDIV-1:0] out_tick;
   logic [CCP_RATIO_W-1:0] ratio [NDIV];

   // System clock runs every core_clk cycle
   assign src_tick[0] = 1'b1;
   assign src_tick[1] = out_tick[0];
   assign src_tick[2] = out_tick[0];
   assign src_tick[3] = adc_from_ahb ? out_tick[0] : out_tick[2];

   assign ratio[0] = ccp_ahb_ratio(cfg_reg[CCP_AHB_LSB +: 4]);
   assign ratio[1] = ccp_apb_ratio(cfg_reg[CCP_APB1_LSB +: 3]);
   assign ratio[2] = ccp_apb_ratio(cfg_reg[CCP_APB2_LSB +: 3]);
   assign ratio[3] = ccp_adc_ratio(adc_code);

   // One divider per derived clock
   genvar gi;
   generate
      for (gi = 0; gi < NDIV; gi++) begin : g_div
         assign div_bus[gi].in_tick = src_tick[gi];
         assign div_bus[gi].ratio = ratio[gi];
         assign out_tick[gi] = div_bus[gi].out_tick;
         ccp_tick_div u_div (
            .core_clk(core_clk),
            .rst(rst),
            .bus(div_bus[gi])
         );
      end
   endgenerate

   // Ticks leave straight from the divider flops
   assign ahb_tick = out_tick[0];
   assign apb1_tick = out_tick[1];
   assign apb2_tick = out_tick[2];
   assign adc_tick = out_tick[3];

endmodule // ccp_clock_config

// File: verif/ccp_clock_checker.sv
/* Port checker for the clock configuration block.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/100ps
module ccp_clock_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic rc8_osc_stable,
   input wire logic rc8_ready,
   input wire logic low_power_exit,
   input wire logic rc8_enable,
   input wire logic usb_clock_enabled,
   input wire logic [3:0] usb_div_x2,
   input wire logic [3:0] clock_out_source,
   input wire logic [5:0] pll_mult_x2,
   input wire logic [1:0] sysclk_source_status,
   input wire logic ahb_tick,
   input wire logic apb1_tick,
   input wire logic apb2_tick,
   input wire logic adc_tick,
   input wire logic predv_lsb_wr,
   input wire logic predv_lsb_wdata,
   input wire logic predivider_low_bit
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Bus request answered after one wait cycle
   sequence s_take;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_bus_answer: assert property (s_take |=> s_answer)
      else $error("bus answer late or long");
   a_ready_low: assert property (!rc8_osc_stable [*5] |-> !rc8_ready)
      else $error("ready without stable oscillator");
   a_wake_enable: assert property (low_power_exit |-> ##[1:3] rc8_enable)
      else $error("wake did not set enable");
   a_usb_frozen: assert property (usb_clock_enabled [*3] |-> $stable(usb_div_x2))
      else $error("usb divider moved while enabled");
   a_usb_range: assert property (usb_div_x2 >= 4'h2 && usb_div_x2 <= 4'h8)
      else $error("usb divisor out of range");
   a_clkout_code: assert property (!(clock_out_source inside {4'h1, 4'h2, 4'h3, 4'he, 4'hf}))
      else $error("clock out code not normalised");
   a_pll_factor: assert property (pll_mult_x2[0] ? pll_mult_x2 == 6'h0d
      : (pll_mult_x2 >= 6'h04 && pll_mult_x2 != 6'h1e))
      else $error("pll factor illegal");
   a_status_code: assert property (sysclk_source_status != 2'h3)
      else $error("reserved status code");
   a_apb1_chain: assert property (apb1_tick |-> $past(ahb_tick))
      else $error("apb1 tick without ahb tick");
   a_apb2_chain: assert property (apb2_tick |-> $past(ahb_tick))
      else $error("apb2 tick without ahb tick");
   a_adc_chain: assert property (adc_tick |-> $past(apb2_tick) || $past(ahb_tick))
      else $error("adc tick without source tick");
   a_mirror_bit: assert property (predv_lsb_wr && !(avs_write && !avs_waitrequest)
      |=> predivider_low_bit == $past(predv_lsb_wdata))
      else $error("mirror bit not updated");
endmodule // ccp_clock_checker

// File: verif/tb.sv
/* Self-checking bench for the clock configuration block.
   Assumes the bench drives every port, with no far-side model. */
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
   import ccp_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0, avs_write = 1'b0, rc8_osc_stable = 1'b0, low_power_exit = 1'b0;
   logic usb_clock_enabled = 1'b0, predv_lsb_wr = 1'b0, predv_lsb_wdata = 1'b0, predv_upper_zero = 1'b0;
   logic crystal_stuck = 1'b0, adc_divider_msb = 1'b0, pll_preselect = 1'b0;
   logic ahb_tick, apb1_tick, apb2_tick, adc_tick;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata, q, d;
   logic avs_waitrequest, rc8_enable, rc8_ready, predivider_low_bit, predv_halve;
   logic [1:0] sysclk_source_status, pll_ref_source;
   logic [3:0] clock_out_source, usb_div_x2;
   logic [5:0] pll_mult_x2;
   logic [3:0] usb_exp [8] = '{4'h3, 4'h2, 4'h5, 4'h4, 4'h6, 4'h7, 4'h8, 4'h8};
   int n_mismatch = 0;
   int comparisons = 0;
   int n_tick [4];
   always #25 core_clk = ~core_clk;
   // Byte lanes held all on; word accesses only
   ccp_clock_config dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rc8_osc_stable(rc8_osc_stable), .crystal_stuck(crystal_stuck),
      .low_power_exit(low_power_exit), .usb_clock_enabled(usb_clock_enabled), .predv_lsb_wr(predv_lsb_wr),
      .predv_lsb_wdata(predv_lsb_wdata), .predv_upper_zero(predv_upper_zero), .adc_divider_msb(adc_divider_msb),
      .pll_preselect(pll_preselect), .rc8_enable(rc8_enable), .rc8_ready(rc8_ready),
      .sysclk_source_status(sysclk_source_status), .ahb_tick(ahb_tick), .apb1_tick(apb1_tick),
      .apb2_tick(apb2_tick), .adc_tick(adc_tick),
      .clock_out_source(clock_out_source), .pll_mult_x2(pll_mult_x2), .usb_div_x2(usb_div_x2),
      .pll_ref_source(pll_ref_source), .predivider_low_bit(predivider_low_bit), .predv_halve(predv_halve));
   // PLL factor times two
   function automatic logic [5:0] pll_x2(int c);
      if (c < 13) return 6'(2 * c + 4);
      if (c == 13) return 6'h0d;
      if (c < 16) return 6'h20;
      if (c < 30) return 6'(2 * c + 2);
      return 6'h3e;
   endfunction
   // One bus cycle; request held until waitrequest seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= ~w;
      // No cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wait_clk(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   // Ticks of each derived clock over k cycles
   task automatic count_ticks(input int k);
      n_tick = '{0, 0, 0, 0};
      repeat (k) begin
         @(posedge core_clk);
         n_tick[0] += int'(ahb_tick === 1'b1);
         n_tick[1] += int'(apb1_tick === 1'b1);
         n_tick[2] += int'(apb2_tick === 1'b1);
         n_tick[3] += int'(adc_tick === 1'b1);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Watchdog; the longest path is under a thousand cycles
   initial begin
      wait_clk(20000);
      n_mismatch++;
      test_done();
   end
   initial begin
      wait_clk(12);
      rst <= 1'b0;
      bus(1'b1, 4'hc, 32'hffff_ffff);
      bus(1'b0, 4'hc, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
      bus(1'b0, 4'h4, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
      `CHK({pll_mult_x2, usb_div_x2, clock_out_source, sysclk_source_status}, 16'h10c0)
      $display("test reset done");
      // Every code of the three decoded fields at once
      for (int c = 0; c < 32; c++) begin
         d = {c[2], 1'b0, c[4], 1'b0, c[3:0], c[1:0], c[3:0], 18'h00000};
         bus(1'b1, 4'h4, d);
         wait_clk(3);
         `CHK(pll_mult_x2, pll_x2(c))
         `CHK(usb_div_x2, usb_exp[c[2:0]])
         `CHK(clock_out_source, (c[3:2] == 2'h0 || c[3:0] > 13) ? 4'h0 : 4'(c[3:0]))
      end
      $display("test decode done");
      // Crystal as PLL reference; reserved select code is stored but leaves the source unchanged; bits 30, 3:2 are ignored on write
      bus(1'b1, 4'h4, 32'h4001_000f);
      bus(1'b0, 4'h4, 32'h0000_0000);
      `CHK(q, 32'h0001_0003)
      wait_clk(10);
      `CHK({pll_ref_source, sysclk_source_status}, 4'h4)
      usb_clock_enabled <= 1'b1;
      // USB divide by 1 write is refused while the USB clock is enabled
      bus(1'b1, 4'h4, 32'h0041_0003);
      bus(1'b0, 4'h4, 32'h0000_0000);
      `CHK(q, 32'h0001_0003)
      usb_clock_enabled <= 1'b0;
      predv_upper_zero <= 1'b1;
      predv_lsb_wr <= 1'b1;
      predv_lsb_wdata <= 1'b1;
      @(posedge core_clk);
      predv_lsb_wr <= 1'b0;
      wait_clk(3);
      `CHK({predivider_low_bit, predv_halve}, 2'h3)
      bus(1'b0, 4'h4, 32'h0000_0000);
      `CHK(q, 32'h0003_0003)
      bus(1'b1, 4'h4, 32'h0000_0000);
      $display("test fields done");
      bus(1'b1, 4'h0, 32'h0000_0001);
      bus(1'b1, 4'h0, 32'h0000_0000);
      bus(1'b0, 4'h0, 32'h0000_0000);
      `CHK(q[1:0], 2'h1)
      rc8_osc_stable <= 1'b1;
      wait_clk(6);
      `CHK(rc8_ready, 1'b1)
      rc8_osc_stable <= 1'b0;
      wait_clk(6);
      `CHK(rc8_ready, 1'b0)
      $display("test oscillator done");
      bus(1'b1, 4'h4, 32'h0000_0001);
      wait_clk(10);
      `CHK(sysclk_source_status, 2'h1)
      bus(1'b1, 4'h0, 32'h0000_0000);
      wait_clk(2);
      `CHK(rc8_enable, 1'b0)
      low_power_exit <= 1'b1;
      @(posedge core_clk);
      low_power_exit <= 1'b0;
      wait_clk(10);
      `CHK({rc8_enable, sysclk_source_status}, 3'h4)
      bus(1'b0, 4'h4, 32'h0000_0000);
      `CHK(q[1:0], 2'h0)
      $display("test switch done");
      // Monitored crystal stuck while in use forces the RC back
      pll_preselect <= 1'b1;
      bus(1'b1, 4'h4, 32'h0001_0001);
      wait_clk(10);
      `CHK({pll_ref_source, sysclk_source_status}, 4'h9)
      bus(1'b1, 4'h0, 32'h0008_0000);
      wait_clk(2);
      `CHK(rc8_enable, 1'b0)
      crystal_stuck <= 1'b1;
      wait_clk(14);
      `CHK({rc8_enable, sysclk_source_status}, 3'h4)
      crystal_stuck <= 1'b0;
      bus(1'b0, 4'h4, 32'h0000_0000);
      `CHK(q[1:0], 2'h0)
      $display("test monitor done");
      // Prescalers: AHB /2, APB1 /4, APB2 /2, ADC /4 of APB2
      bus(1'b1, 4'h4, 32'h0000_6580);
      wait_clk(40);
      count_ticks(80);
      `CHK(n_tick[0], 40)
      `CHK(n_tick[1], 10)
      `CHK(n_tick[2], 20)
      `CHK(n_tick[3], 5)
      adc_divider_msb <= 1'b1;
      wait_clk(40);
      count_ticks(80);
      `CHK(n_tick[3], 8)
      $display("test prescaler done");
      test_done();
   end
endmodule // tb
bind ccp_clock_config ccp_clock_checker chk (.core_clk(core_clk), .rst(rst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .rc8_osc_stable(rc8_osc_stable),
   .rc8_ready(rc8_ready), .low_power_exit(low_power_exit), .rc8_enable(rc8_enable),
   .usb_clock_enabled(usb_clock_enabled), .usb_div_x2(usb_div_x2), .clock_out_source(clock_out_source),
   .pll_mult_x2(pll_mult_x2), .sysclk_source_status(sysclk_source_status), .ahb_tick(ahb_tick),
   .apb1_tick(apb1_tick), .apb2_tick(apb2_tick), .adc_tick(adc_tick), .predv_lsb_wr(predv_lsb_wr),
   .predv_lsb_wdata(predv_lsb_wdata), .predivider_low_bit(predivider_low_bit));
